/* hw/rot_pkg.sv */
// Shared constants of the oscillation trim block
package rot_pkg;

	// ==========================================================
	// Trim code layout
	localparam int unsigned ROT_TRIM_W        = 7;
	localparam int unsigned ROT_TRIM_TOP_POS  = 6;
	localparam logic [6:0]  ROT_TRIM_RST      = 7'h00;
	localparam logic [6:0]  ROT_SLOW_FIRST    = 7'h02;
	localparam logic [6:0]  ROT_SLOW_OFFSET   = 7'h01;
	localparam logic [6:0]  ROT_FAST_FIRST    = 7'h42;
	localparam logic [7:0]  ROT_FAST_BASE     = 8'h80;

	// ==========================================================
	// Time counting
	localparam int unsigned ROT_OSC_HZ         = 32768;
	localparam int unsigned ROT_INTERVAL_S     = 20;
	localparam int unsigned ROT_TICKS_PER_STEP = 2;
	localparam int unsigned ROT_PRE_W          = 17;
	localparam int unsigned ROT_SEC_CNT_W      = 5;
	localparam int unsigned ROT_SYNC_STAGES    = 2;

endpackage

/* hw/rot_sync.sv */
// Two-stage synchroniser for a level from outside the clock domain
module rot_sync (
	// Clock, reset, enable
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// Level in and out
	input  wire logic d_i,
	output logic      q_o
);
	typedef struct packed {
		logic meta;
		logic sync;
	} rot_sync_state_t;

	rot_sync_state_t s_reg;
	rot_sync_state_t s_next;

	always_comb begin
		s_next      = s_reg;
		s_next.meta = d_i;
		s_next.sync = s_reg.meta;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	assign q_o = s_reg.sync;
endmodule

/* hw/rot_trim.sv */
// Time-count trim: 1 Hz count from the crystal clock, corrected once per 20 s
// What this block does
// R1: Once per 20-second interval, lengthen or shorten one second of the count.
// R2: The trim value is a 7-bit code written by the host.
// R3: Code with six low bits zero, either top bit, applies no correction.
// R4: Codes meaning 0, +1, -64 and -63 give no net correction.
// R5: Positive code minus 01h gives the number of slowing steps.
// R6: 80h minus the code gives the number of speeding steps.
// R7: The crystal clock is driven out on the sub-clock output pin.
// R8: Each step is about 3.05 ppm, up to 189.2 ppm either way.
// R9: Trim changes only the time count, never the sub-clock frequency.
// R10: While the oscillation-halt flag is set, all seven trim bits clear to zero.
module rot_trim
	import rot_pkg::*;
#(
	parameter int unsigned TICKS_PER_SEC = rot_pkg::ROT_OSC_HZ,
	parameter int unsigned INTERVAL_S    = rot_pkg::ROT_INTERVAL_S
) (
	// Clock, reset, enable
	input  wire logic                         REF_CLK_I,
	input  wire logic                         RST_I,
	input  wire logic                         CE_I,
	// Crystal clock from the oscillator pin
	input  wire logic                         OSC_CLK_I,
	// Trim code write port and halt flag
	input  wire logic                         TRIM_WR_I,
	input  wire logic [rot_pkg::ROT_TRIM_W-1:0] TRIM_DATA_I,
	input  wire logic                         OSC_HALT_FLAG_I,
	// Outputs
	output logic                              SUB_CLOCK_OUT_PIN_O,
	output logic [rot_pkg::ROT_TRIM_W-1:0]    TRIM_O,
	output logic                              SEC_PULSE_O,
	output logic                              INTERVAL_END_O
);
	import rot_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic                     osc_prev;
		logic                     sub_clk;
		logic [ROT_TRIM_W-1:0]    trim;
		logic [ROT_PRE_W-1:0]     pre;
		logic [ROT_SEC_CNT_W-1:0] sec_cnt;
		logic                     sec_pulse;
		logic                     int_end;
	} rot_state_t;

	localparam logic [ROT_PRE_W-1:0]     PRE_BASE = ROT_PRE_W'(TICKS_PER_SEC - 1);
	localparam logic [ROT_SEC_CNT_W-1:0] SEC_LAST = ROT_SEC_CNT_W'(INTERVAL_S - 1);
	localparam logic [ROT_PRE_W-1:0]     STEP_TICKS = ROT_PRE_W'(ROT_TICKS_PER_STEP);

	rot_state_t s_reg;
	rot_state_t s_next;
	logic       osc_sync;

	// ==========================================================
	// Crystal clock crossing
	rot_sync u_osc_sync (
		.clk_i (REF_CLK_I),
		.rst_i (RST_I),
		.ce_i  (CE_I),
		.d_i   (OSC_CLK_I),
		.q_o   (osc_sync)
	);

	// ==========================================================
	// Trim decode
	logic                  trim_slow;
	logic                  trim_fast;
	logic [ROT_TRIM_W-1:0] trim_steps;
	logic [ROT_PRE_W-1:0]  trim_ticks;
	logic [ROT_PRE_W-1:0]  pre_limit;

	always_comb begin
		// R3: no correction for codes 00h, 01h, 40h, 41h
		// R4: those four codes fall outside both step ranges
		trim_slow  = !s_reg.trim[ROT_TRIM_TOP_POS] && (s_reg.trim >= ROT_SLOW_FIRST);
		trim_fast  = s_reg.trim[ROT_TRIM_TOP_POS] && (s_reg.trim >= ROT_FAST_FIRST);
		trim_steps = '0;
		if (trim_slow) begin
			// R5: distance above 01h
			trim_steps = s_reg.trim - ROT_SLOW_OFFSET;
		end else if (trim_fast) begin
			// R6: distance below 80h
			trim_steps = ROT_TRIM_W'(ROT_FAST_BASE - {1'b0, s_reg.trim});
		end
		// R8: each step is two crystal ticks out of 20 s, about 3.05 ppm
		trim_ticks = ROT_PRE_W'({{(ROT_PRE_W - ROT_TRIM_W){1'b0}}, trim_steps} * STEP_TICKS);
		pre_limit  = PRE_BASE;
		// R1: only the last second of each interval is stretched or shortened
		if (s_reg.sec_cnt == SEC_LAST) begin
			if (trim_slow) begin
				pre_limit = PRE_BASE + trim_ticks;
			end else if (trim_fast) begin
				pre_limit = PRE_BASE - trim_ticks;
			end
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		s_next           = s_reg;
		s_next.sec_pulse = 1'b0;
		s_next.int_end   = 1'b0;
		s_next.osc_prev  = osc_sync;
		// R7: crystal clock passes straight to the sub-clock pin
		// R9: the trim path never touches this copy
		s_next.sub_clk   = osc_sync;

		// R10: halt flag holds the code cleared and beats a write
		if (OSC_HALT_FLAG_I) begin
			s_next.trim = ROT_TRIM_RST;
		end else if (TRIM_WR_I) begin
			// R2: host loads the 7-bit code
			s_next.trim = TRIM_DATA_I;
		end

		// Count crystal rising edges; >= covers a limit lowered mid-second
		if (osc_sync && !s_reg.osc_prev) begin
			if (s_reg.pre >= pre_limit) begin
				s_next.pre       = '0;
				s_next.sec_pulse = 1'b1;
				if (s_reg.sec_cnt >= SEC_LAST) begin
					s_next.sec_cnt = '0;
					s_next.int_end = 1'b1;
				end else begin
					s_next.sec_cnt = s_reg.sec_cnt + 1'b1;
				end
			end else begin
				s_next.pre = s_reg.pre + 1'b1;
			end
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			s_reg <= '0;
		end else if (CE_I) begin
			s_reg <= s_next;
		end
	end

	assign SUB_CLOCK_OUT_PIN_O = s_reg.sub_clk;
	assign TRIM_O              = s_reg.trim;
	assign SEC_PULSE_O         = s_reg.sec_pulse;
	assign INTERVAL_END_O      = s_reg.int_end;
endmodule

/* tb/rot_trim_sva.sv */
// Port checker of the trim block
module rot_trim_sva
	import rot_pkg::*;
(
	input wire logic REF_CLK_I, RST_I, CE_I, OSC_CLK_I, TRIM_WR_I, OSC_HALT_FLAG_I,
	input wire logic SUB_CLOCK_OUT_PIN_O, SEC_PULSE_O, INTERVAL_END_O,
	input wire logic [ROT_TRIM_W-1:0] TRIM_DATA_I, TRIM_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	sequence s_wr;
		CE_I && TRIM_WR_I && !OSC_HALT_FLAG_I;
	endsequence
	sequence s_run;
		// Reset cycles are left out: the pipe is cleared there, not a copy of the pin
		(CE_I && !RST_I) [*4];
	endsequence
	chk_trim_write: assert property (s_wr |=> TRIM_O == $past(TRIM_DATA_I))
		else $error("trim write lost");
	chk_trim_hold: assert property (CE_I && !TRIM_WR_I && !OSC_HALT_FLAG_I |=> $stable(TRIM_O))
		else $error("trim moved without write");
	chk_halt_clear: assert property (CE_I && OSC_HALT_FLAG_I |=> TRIM_O == '0)
		else $error("trim kept during halt");
	chk_sub_clock: assert property (s_run |-> SUB_CLOCK_OUT_PIN_O == $past(OSC_CLK_I, 3))
		else $error("sub clock not a copy");
	chk_end_pair: assert property (INTERVAL_END_O |-> SEC_PULSE_O)
		else $error("interval end without second");
	chk_sec_single: assert property (SEC_PULSE_O |=> !SEC_PULSE_O)
		else $error("second pulse too long");
	chk_sec_edge: assert property (SEC_PULSE_O |-> $rose(SUB_CLOCK_OUT_PIN_O))
		else $error("second off crystal edge");
	chk_reset_idle: assert property (disable iff (1'b0) RST_I |=> TRIM_O == '0 && !SEC_PULSE_O)
		else $error("outputs busy in reset");
endmodule

bind rot_trim rot_trim_sva rot_trim_sva_i (.*);

/* tb/rot_osc_model.sv */
// Free-running crystal clock source
module rot_osc_model #(parameter int HALF_NS = 20) (output logic osc_o);
	timeunit 1ns;
	timeprecision 1ns;
	// crystal runs free, phase unrelated to the system clock
	initial begin
		osc_o = 1'b0;
		#3;
		forever #HALF_NS osc_o = ~osc_o;
	end
endmodule

/* tb/rot_trim_tb.sv */
// Testbench of the trim block
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module rot_trim_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import rot_pkg::*;
	localparam int T = 130;
	logic clk = 0, rst = 1, ce = 1, osc, wr = 0, halt = 0, sub, sec, iend, pv = 0;
	logic [6:0] d = 7'h00, trim;
	int n_errors = 0, checks_done = 0, n;
	always #4 clk = ~clk;
	rot_osc_model rot_osc_model_i (.osc_o(osc));
	rot_trim #(.TICKS_PER_SEC(T), .INTERVAL_S(2)) rot_trim_i (.REF_CLK_I(clk), .RST_I(rst), .CE_I(ce),
		.OSC_CLK_I(osc), .TRIM_WR_I(wr), .TRIM_DATA_I(d), .OSC_HALT_FLAG_I(halt),
		.SUB_CLOCK_OUT_PIN_O(sub), .TRIM_O(trim), .SEC_PULSE_O(sec), .INTERVAL_END_O(iend));
	task automatic print_verdict();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic put(input logic [6:0] c);
		@(negedge clk) begin wr = 1; d = c; end
		@(negedge clk) wr = 0;
	endtask
	// Crystal edges up to and including the next interval end
	task automatic wait_end(output int k);
		k = 0;
		for (int i = 0; i < 4000; i++) begin
			@(negedge clk);
			if (sub && !pv) k++;
			pv = sub;
			if (iend) return;
		end
		n_errors++;
		print_verdict();
	endtask
	task automatic t_codes();
		logic [6:0] c [10] = '{7'h00, 7'h01, 7'h40, 7'h41, 7'h02, 7'h3F, 7'h42, 7'h7F, 7'h09, 7'h57};
		int e;
		foreach (c[i]) begin
			put(c[i]);
			`CHK(trim, c[i])
			e = (c[i] >= 2 && c[i] <= 63) ? 2*T + 2*(c[i]-1) : (c[i] >= 66) ? 2*T - 2*(128-c[i]) : 2*T;
			wait_end(n);
			wait_end(n);
			`CHK(n, e)
		end
	endtask
	task automatic t_halt();
		put(7'h15);
		@(negedge clk) halt = 1;
		put(7'h2A);
		`CHK(trim, 7'h00)
		@(negedge clk) halt = 0;
		@(negedge clk) ce = 0;
		put(7'h33);
		`CHK(trim, 7'h00)
		ce = 1;
		@(negedge clk) begin wr = 1; d = 7'h11; end
		@(negedge clk) d = 7'h6E;
		@(negedge clk) wr = 0;
		`CHK(trim, 7'h6E)
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst = 0;
		t_halt();
		t_codes();
		print_verdict();
	end
endmodule
